// *** include/scrs_regs.svh ***
// What this block does
// - select code 1010 loads temp ADC control
// - ADC clock is PFD clock over divider
// - ADC divider taken from DB13:DB6
// - unprogrammed reference factor behaves as one
// - DB5 set with DB4 set starts conversion on write
// - DB4 set powers the temperature ADC
// - select code 1100 loads resync timeout
// - DB31:DB16 counts PFD clocks before resync
// - frequency changes only on register 0 write
// - primary modulus fixed at two to 24
// - PFD is reference times doubler over R, T
// - low four bits select target register
//
// Purpose: constants of the synthesizer configuration register sequencer
// Assumes: 32-bit words, four-bit select code in the lowest bits
// Notes: field positions of the reference word are local choices
`ifndef SCRS_REGS_SVH
`define SCRS_REGS_SVH
`define SCRS_SEL_INT 4'h0
`define SCRS_SEL_FRAC 4'h1
`define SCRS_SEL_AUXILIARY_MODULUS 4'h2
`define SCRS_SEL_REF 4'h4
`define SCRS_SEL_TEMP_ADC 4'ha
`define SCRS_SEL_FIXED 4'hb
`define SCRS_SEL_RESYNC 4'hc
`define SCRS_NUM_WORDS 13
`define SCRS_ADC_DIV_HI 13
`define SCRS_ADC_DIV_LO 6
`define SCRS_CONVERT_BIT 5
`define SCRS_ADC_POWER_BIT 4
`define SCRS_RESYNC_HI 31
`define SCRS_RESYNC_LO 16
`define SCRS_REF_R_HI 24
`define SCRS_REF_R_LO 15
`define SCRS_REF_DOUBLER_BIT 26
`define SCRS_REF_HALF_BIT 25
`define SCRS_PRIMARY_FRACTION_HI 27
`define SCRS_PRIMARY_FRACTION_LO 4
`define SCRS_MODULUS_BITS 24
`define SCRS_CONV_CYCLES 5'h10
`define SCRS_WORD_RESET 32'h00000000
`endif

// *** include/scrs_pkg.sv ***
// Purpose: types of the synthesizer configuration register sequencer
// Assumes: constants come from scrs_regs.svh
// Notes: the module state apart from the reset synchronizer is one packed struct
package scrs_pkg;
    typedef struct packed {
        logic [2:0] sync_sclk;
        logic [2:0] sync_sdata;
        logic [2:0] sync_le;
        logic [2:0] sync_ref;
        logic sclk;
        logic sdata;
        logic le;
        logic ref_in;
        logic [31:0] shift;
        logic [12:0][31:0] staged;
        logic [12:0] written;
        logic [31:0] act_int;
        logic [31:0] act_frac;
        logic [31:0] act_auxiliary_modulus;
        logic [31:0] act_ref;
        logic ref_loaded;
        logic commit;
        logic [10:0] ref_cnt;
        logic pfd_tick;
        logic [7:0] adc_cnt;
        logic adc_tick;
        logic [4:0] conv_cnt;
        logic conv_start;
        logic resync_arm;
        logic [15:0] resync_cnt;
        logic resync;
        logic [23:0] frac_acc;
        logic frac_carry;
    } scrs_state_t;
endpackage

// *** logic/scrs_top.sv ***
// Purpose: serial configuration registers of a fractional-N synthesizer
// Assumes: serial pins and reference input are asynchronous to i_clock
// Notes: ticks of the PFD and ADC clocks are one-cycle enables on i_clock
`timescale 1ns/1ps
`include "scrs_regs.svh"
module scrs_top
(
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_sclk,
    input wire logic i_sdata,
    input wire logic i_le,
    input wire logic i_ref,
    output logic [31:0] o_int_word,
    output logic [31:0] o_frac_word,
    output logic [31:0] o_auxiliary_modulus_word,
    output logic [31:0] o_ref_word,
    output logic [31:0] o_temp_adc_control,
    output logic [31:0] o_fixed_reserved_word,
    output logic [31:0] o_resync_timeout_control,
    output logic o_commit,
    output logic o_pfd_tick,
    output logic o_adc_tick,
    output logic [7:0] o_temp_adc_divider,
    output logic o_temp_adc_power,
    output logic o_convert_start,
    output logic o_convert_busy,
    output logic o_resync,
    output logic o_frac_carry
);
    logic [1:0] rst_sync;
    logic rst_n;
    scrs_pkg::scrs_state_t q;
    scrs_pkg::scrs_state_t next_q;

    function automatic logic [10:0] ref_limit(input logic [31:0] w, input logic loaded);
        logic [9:0] r;
        logic [10:0] f;
        r = w[`SCRS_REF_R_HI:`SCRS_REF_R_LO];
        if (!loaded || r == 10'h000)
        begin
            r = 10'h001;
        end
        f = {1'b0, r};
        if (w[`SCRS_REF_HALF_BIT])
        begin
            f = {r, 1'b0};
        end
        return f;
    endfunction

    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            rst_sync <= 2'h0;
        end
        else
        begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    always_comb
    begin
        logic [31:0] word;
        logic [3:0] sel;
        logic ref_edge;
        logic [24:0] sum;
        word = q.shift;
        sel = q.shift[3:0];
        ref_edge = 1'b0;
        sum = 25'h0;
        next_q = q;
        next_q.commit = 1'b0;
        next_q.pfd_tick = 1'b0;
        next_q.adc_tick = 1'b0;
        next_q.conv_start = 1'b0;
        next_q.resync = 1'b0;
        next_q.frac_carry = 1'b0;

        // pins pass three flops; a change counts once the last two agree
        next_q.sync_sclk = {q.sync_sclk[1:0], i_sclk};
        next_q.sync_sdata = {q.sync_sdata[1:0], i_sdata};
        next_q.sync_le = {q.sync_le[1:0], i_le};
        next_q.sync_ref = {q.sync_ref[1:0], i_ref};
        if (q.sync_sclk[2] == q.sync_sclk[1])
        begin
            next_q.sclk = q.sync_sclk[2];
        end
        if (q.sync_sdata[2] == q.sync_sdata[1])
        begin
            next_q.sdata = q.sync_sdata[2];
        end
        if (q.sync_le[2] == q.sync_le[1])
        begin
            next_q.le = q.sync_le[2];
        end
        if (q.sync_ref[2] == q.sync_ref[1])
        begin
            next_q.ref_in = q.sync_ref[2];
        end

        if (next_q.sclk && !q.sclk)
        begin
            next_q.shift = {q.shift[30:0], q.sdata};
        end

        if (next_q.le && !q.le)
        begin
            if (sel < 4'(`SCRS_NUM_WORDS))
            begin
                next_q.staged[sel] = word;
                next_q.written[sel] = 1'b1;
            end
            if (sel == `SCRS_SEL_INT)
            begin
                next_q.commit = 1'b1;
                next_q.act_int = word;
                next_q.act_frac = q.staged[`SCRS_SEL_FRAC];
                next_q.act_auxiliary_modulus = q.staged[`SCRS_SEL_AUXILIARY_MODULUS];
                next_q.act_ref = q.staged[`SCRS_SEL_REF];
                next_q.ref_loaded = q.written[`SCRS_SEL_REF];
                next_q.resync_arm = 1'b1;
                next_q.resync_cnt = q.staged[`SCRS_SEL_RESYNC][`SCRS_RESYNC_HI:`SCRS_RESYNC_LO];
            end
            if (sel == `SCRS_SEL_TEMP_ADC)
            begin
                if (word[`SCRS_CONVERT_BIT] && word[`SCRS_ADC_POWER_BIT])
                begin
                    next_q.conv_start = 1'b1;
                    next_q.conv_cnt = `SCRS_CONV_CYCLES;
                end
            end
        end

        if (q.act_ref[`SCRS_REF_DOUBLER_BIT])
        begin
            ref_edge = next_q.ref_in != q.ref_in;
        end
        else
        begin
            ref_edge = next_q.ref_in && !q.ref_in;
        end
        if (ref_edge)
        begin
            if (q.ref_cnt + 11'h001 >= ref_limit(q.act_ref, q.ref_loaded))
            begin
                next_q.ref_cnt = 11'h000;
                next_q.pfd_tick = 1'b1;
            end
            else
            begin
                next_q.ref_cnt = q.ref_cnt + 11'h001;
            end
        end

        if (q.pfd_tick && q.staged[`SCRS_SEL_TEMP_ADC][`SCRS_ADC_POWER_BIT])
        begin
            if (q.adc_cnt + 8'h01 >= q.staged[`SCRS_SEL_TEMP_ADC][`SCRS_ADC_DIV_HI:`SCRS_ADC_DIV_LO])
            begin
                next_q.adc_cnt = 8'h00;
                // a zero divider keeps the converter stopped
                next_q.adc_tick = q.staged[`SCRS_SEL_TEMP_ADC][`SCRS_ADC_DIV_HI:`SCRS_ADC_DIV_LO] != 8'h00;
            end
            else
            begin
                next_q.adc_cnt = q.adc_cnt + 8'h01;
            end
        end

        if (q.adc_tick && q.conv_cnt != 5'h00 && !next_q.conv_start)
        begin
            next_q.conv_cnt = q.conv_cnt - 5'h01;
        end

        if (q.pfd_tick && q.resync_arm && !next_q.commit)
        begin
            if (q.resync_cnt <= 16'h0001)
            begin
                next_q.resync = 1'b1;
                next_q.resync_arm = 1'b0;
                next_q.resync_cnt = 16'h0000;
            end
            else
            begin
                next_q.resync_cnt = q.resync_cnt - 16'h0001;
            end
        end

        if (q.pfd_tick)
        begin
            sum = {1'b0, q.frac_acc} + {1'b0, q.act_frac[`SCRS_PRIMARY_FRACTION_HI:`SCRS_PRIMARY_FRACTION_LO]};
            next_q.frac_acc = sum[`SCRS_MODULUS_BITS-1:0];
            next_q.frac_carry = sum[`SCRS_MODULUS_BITS];
        end
    end

    always_ff @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q <= '0;
        end
        else
        begin
            q <= next_q;
        end
    end

    assign o_int_word = q.act_int;
    assign o_frac_word = q.act_frac;
    assign o_auxiliary_modulus_word = q.act_auxiliary_modulus;
    assign o_ref_word = q.act_ref;
    assign o_temp_adc_control = q.staged[`SCRS_SEL_TEMP_ADC];
    assign o_fixed_reserved_word = q.staged[`SCRS_SEL_FIXED];
    assign o_resync_timeout_control = q.staged[`SCRS_SEL_RESYNC];
    assign o_commit = q.commit;
    assign o_pfd_tick = q.pfd_tick;
    assign o_adc_tick = q.adc_tick;
    assign o_temp_adc_divider = q.staged[`SCRS_SEL_TEMP_ADC][`SCRS_ADC_DIV_HI:`SCRS_ADC_DIV_LO];
    assign o_temp_adc_power = q.staged[`SCRS_SEL_TEMP_ADC][`SCRS_ADC_POWER_BIT];
    assign o_convert_start = q.conv_start;
    assign o_convert_busy = q.conv_cnt != 5'h00;
    assign o_resync = q.resync;
    assign o_frac_carry = q.frac_carry;
endmodule

// *** dv/scrs_host_model.sv ***
// Purpose: host side of the three-wire programming link
// Assumes: levels held four clocks so the pin filter sees them
// Notes: serial clock rests low between words
`timescale 1ns/1ps
module scrs_host_model
(
    input wire logic i_clock,
    output logic o_sclk,
    output logic o_sdata,
    output logic o_le
);
    initial
    begin
        o_sclk = 1'b0;
        o_sdata = 1'b0;
        o_le = 1'b0;
    end
    task automatic hold();
        repeat (4) @(posedge i_clock);
    endtask
    task automatic write_word(input logic [31:0] word);
        for (int i = 31; i >= 0; i--)
        begin
            o_sdata <= word[i];
            hold();
            o_sclk <= 1'b1;
            hold();
            o_sclk <= 1'b0;
        end
        o_le <= 1'b1;
        hold();
        o_le <= 1'b0;
        // released data must not keep looking valid
        o_sdata <= ~word[0];
        hold();
    endtask
endmodule

// *** dv/scrs_top_monitor.sv ***
// Purpose: port checker of the config register sequencer
// Assumes: one clock, active-low reset
// Notes: attached by the bind below
`timescale 1ns/1ps
module scrs_top_monitor
(
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic [31:0] o_int_word,
    input wire logic [31:0] o_frac_word,
    input wire logic [31:0] o_temp_adc_control,
    input wire logic [31:0] o_resync_timeout_control,
    input wire logic o_commit,
    input wire logic o_pfd_tick,
    input wire logic o_adc_tick,
    input wire logic [7:0] o_temp_adc_divider,
    input wire logic o_temp_adc_power,
    input wire logic o_convert_start,
    input wire logic o_convert_busy,
    input wire logic o_resync
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rstn);
    sequence s_one(sig);
        sig ##1 !sig;
    endsequence
    chk_temp_select: assert property
        ($changed(o_temp_adc_control) |-> o_temp_adc_control[3:0] == 4'ha) else $error("bad temp select");
    chk_resync_select: assert property
        ($changed(o_resync_timeout_control) |-> o_resync_timeout_control[3:0] == 4'hc) else $error("bad select");
    chk_int_commit: assert property
        ($changed(o_int_word) |-> o_commit && o_int_word[3:0] == 4'h0) else $error("int word moved");
    chk_frac_pending: assert property
        ($changed(o_frac_word) |-> o_commit) else $error("frac word moved early");
    chk_commit_pulse: assert property
        (o_commit |-> s_one(o_commit)) else $error("commit not a pulse");
    chk_div_field: assert property
        (o_temp_adc_divider == o_temp_adc_control[13:6]) else $error("divider field");
    chk_start_cause: assert property
        (o_convert_start |-> o_temp_adc_control[5:4] == 2'h3 && o_temp_adc_control[3:0] == 4'ha)
        else $error("stray start");
    chk_start_busy: assert property
        (o_convert_start |-> s_one(o_convert_start) ##0 o_convert_busy) else $error("no busy");
    chk_resync_tick: assert property
        (o_resync |-> $past(o_pfd_tick)) else $error("resync off tick");
    chk_adc_after_pfd: assert property
        (o_adc_tick |-> $past(o_pfd_tick)) else $error("adc tick off pfd tick");
    chk_adc_powered: assert property
        (o_adc_tick |-> $past(o_temp_adc_power)) else $error("adc tick while powered down");
endmodule
bind scrs_top scrs_top_monitor scrs_top_monitor_i (.*);

// *** dv/synth_config_register_sequencer_tb.sv ***
// Purpose: self-checking bench of the config register sequencer
// Assumes: host model drives the serial pins
// Notes: reference pin toggles every four clocks
`timescale 1ns/1ps
module synth_config_register_sequencer_tb;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic ref_pin = 1'b0;
    logic sclk, sdata, le;
    logic [31:0] int_word, frac_word, auxiliary_modulus_word, ref_word, temp_word, fixed_word, resync_word;
    logic [7:0] adc_div;
    logic commit, pfd_tick, adc_tick, adc_power, conv_start, conv_busy, resync, frac_carry;
    int mismatches = 0;
    int compares = 0;
    int pfd_count = 0;
    int carry_count = 0;
    int pfd_since = 0;
    int resync_at = -1;
    int adc_gap = 0;
    int last_gap = 0;
    int starts = 0;
    always #4 clock = ~clock;
    always
    begin
        repeat (4) @(posedge clock);
        ref_pin <= ~ref_pin;
    end
    scrs_host_model scrs_host_model_i (.i_clock(clock), .o_sclk(sclk), .o_sdata(sdata), .o_le(le));
    scrs_top scrs_top_i
    (
        .i_clock(clock), .i_rstn(rstn), .i_sclk(sclk), .i_sdata(sdata), .i_le(le), .i_ref(ref_pin),
        .o_int_word(int_word), .o_frac_word(frac_word), .o_auxiliary_modulus_word(auxiliary_modulus_word), .o_ref_word(ref_word),
        .o_temp_adc_control(temp_word), .o_fixed_reserved_word(fixed_word),
        .o_resync_timeout_control(resync_word), .o_commit(commit), .o_pfd_tick(pfd_tick),
        .o_adc_tick(adc_tick), .o_temp_adc_divider(adc_div), .o_temp_adc_power(adc_power),
        .o_convert_start(conv_start), .o_convert_busy(conv_busy), .o_resync(resync), .o_frac_carry(frac_carry)
    );
    // tick bookkeeping kept here so expectations never read design state
    always @(posedge clock)
    begin
        pfd_count <= pfd_count + int'(pfd_tick === 1'b1);
        carry_count <= carry_count + int'(frac_carry === 1'b1);
        // a tick standing with the commit pulse already counts toward the timeout
        pfd_since <= (commit === 1'b1) ? int'(pfd_tick === 1'b1) : pfd_since + int'(pfd_tick === 1'b1);
        starts <= starts + int'(conv_start === 1'b1);
        adc_gap <= (adc_tick === 1'b1) ? 0 : adc_gap + int'(pfd_tick === 1'b1);
        if (adc_tick === 1'b1)
            last_gap <= adc_gap;
        if (resync === 1'b1)
            resync_at <= pfd_since;
    end
    task automatic wrap_up();
        if (mismatches == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic near(input int got, input int exp);
        check(32'(got >= exp - 1 && got <= exp + 1), 32'h1);
    endtask
    // phase of the tick train is unknown, hence the one-tick slack
    task automatic measure(input int cycles, input int exp_pfd, input int exp_carry);
        int p;
        int c;
        p = pfd_count;
        c = carry_count;
        repeat (cycles) @(posedge clock);
        near(pfd_count - p, exp_pfd);
        near(carry_count - c, exp_carry);
    endtask
    task automatic wr(input logic [31:0] w);
        scrs_host_model_i.write_word(w);
    endtask
    initial
    begin
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        repeat (8) @(posedge clock);
        check(int_word, 32'h0);
        measure(160, 20, 0);
        wr(32'h0002050c);
        wr(32'h0081200b);
        wr(32'h00c000fa);
        check(temp_word, 32'h00c000fa);
        check(32'(adc_div), 32'h3);
        check(32'(adc_power), 32'h1);
        check(32'(conv_busy), 32'h1);
        check(resync_word, 32'h0002050c);
        check(fixed_word, 32'h0081200b);
        check(32'(starts), 32'h1);
        wr(32'h00000322);
        wr(32'h08000001);
        wr(32'hfffffffd);
        check(frac_word, 32'h0);
        check(temp_word, 32'h00c000fa);
        repeat (400) @(posedge clock);
        check(32'(conv_busy), 32'h0);
        check(32'(last_gap), 32'h3);
        wr(32'h00000440);
        check(int_word, 32'h00000440);
        check(frac_word, 32'h08000001);
        check(auxiliary_modulus_word, 32'h00000322);
        measure(160, 20, 10);
        check(32'(resync_at), 32'h2);
        wr(32'h06010004);
        check(ref_word, 32'h0);
        wr(32'h00000440);
        check(ref_word, 32'h06010004);
        measure(320, 20, 10);
        wr(32'h04008004);
        wr(32'h00000440);
        check(ref_word, 32'h04008004);
        measure(160, 40, 20);
        wr(32'h00c000da);
        check(temp_word, 32'h00c000da);
        check(32'(conv_busy), 32'h0);
        check(32'(starts), 32'h1);
        wrap_up();
    end
    initial
    begin
        repeat (10000) @(posedge clock);
        mismatches++;
        wrap_up();
    end
endmodule
